/* File: logic/calib_enh_regs.sv */
// calibration result and enhancement enable register bank
`timescale 1ns/1ps
module calib_enh_regs
    import calib_enh_pkg::*;
#(
    parameter bit HAS_CONVERTER = 1'b1,
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int BOOST_CYCLES = BOOST_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic ringBurstEnd,
    input wire logic [5:0] programmedCurrentLimit,
    input wire logic relaySelectBit,
    input wire logic externalBatterySelect,
    input wire logic lowBatteryReq,
    input wire logic [15:0] loopCurrent,
    input wire logic [15:0] tipRingVoltage,
    input wire logic [15:0] closeThreshUpper,
    input wire logic [15:0] closeThreshLower,
    output logic [3:0] monitorOffsetResultA,
    output logic [3:0] monitorOffsetResultB,
    output logic dacPlusTrim,
    output logic dacMinusTrim,
    output logic adcPlusTrim,
    output logic adcMinusTrim,
    output logic [7:0] audioDacOffsetResult,
    output logic [5:0] commonModeBalanceResult,
    output logic [3:0] dcPeakMonitorResult,
    output logic [5:0] loopLimitMa,
    output logic boostActive,
    output logic fskMode,
    output logic toneTick,
    output logic converterSpeedup,
    output logic externalImpedanceRef,
    output logic batteryLowSel,
    output logic voltageLoopClosure,
    output logic converterSquelch,
    output logic loopClosed
);
    // ==========================================================
    // elaboration checks
    // debounce and boost counters are CNT_W wide, a larger count would wrap silently
    if (DEBOUNCE_CYCLES < 1
        || DEBOUNCE_CYCLES >= (1 << CNT_W)) begin : debounce_range_chk
        $error("debounce count out of range");
    end
    if (BOOST_CYCLES < 1
        || BOOST_CYCLES >= (1 << CNT_W)) begin : boost_range_chk
        $error("boost count out of range");
    end

    localparam logic [7:0] MASK_ENH =
        HAS_CONVERTER ? MASK_ENH_CONV : MASK_ENH_NOCONV;

    logic waitrequest_r;
    logic [31:0] readdata_r;
    logic [7:0] mon_r;
    logic [7:0] trim_r;
    logic [7:0] dac_r;
    logic [7:0] cm_r;
    logic [7:0] dcpk_r;
    logic [7:0] enh_r;
    logic [7:0] rdByte;
    logic [7:0] idx;
    logic wrEn;
    logic boostActive_r;
    logic [CNT_W-1:0] boostCnt_r;
    logic [5:0] loopLimitMa_r;
    logic fskMode_r;
    logic [TONE_W-1:0] toneCnt_r;
    logic [TONE_W-1:0] toneDiv;
    logic toneTick_r;
    logic batteryLowSel_r;
    logic [CNT_W-1:0] dbCnt_r;
    logic dbActive;
    logic [15:0] measure;
    logic loopClosed_r;

    // ==========================================================
    // avalon slave, one wait cycle per access
    assign idx = address[9:2];
    // write lands only at the edge where waitrequest is low
    assign wrEn = write && !waitrequest_r && byteenable[0]
        && (address[1:0] == 2'b00);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest_r <= 1'b1;
        end else if (waitrequest_r && (read || write)) begin
            waitrequest_r <= 1'b0;
        end else begin
            waitrequest_r <= 1'b1;
        end
    end

    always_comb begin
        rdByte = 8'h00;
        if (address[1:0] == 2'b00) begin
            case (idx)
                IDX_MON: rdByte = mon_r;
                IDX_TRIM: rdByte = trim_r;
                IDX_DAC: rdByte = dac_r;
                IDX_CM: rdByte = cm_r;
                IDX_DCPK: rdByte = dcpk_r;
                IDX_ENH: rdByte = enh_r;
                default: rdByte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            readdata_r <= 32'h0000_0000;
        end else if (waitrequest_r && read) begin
            readdata_r <= {24'h00_0000, rdByte};
        end
    end

    // ==========================================================
    // register storage, reserved bits masked on write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mon_r <= RST_MON;
        end else if (wrEn && idx == IDX_MON) begin
            mon_r <= writedata[7:0] & MASK_MON;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trim_r <= RST_TRIM;
        end else if (wrEn && idx == IDX_TRIM) begin
            trim_r <= writedata[7:0] & MASK_TRIM;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dac_r <= RST_DAC;
        end else if (wrEn && idx == IDX_DAC) begin
            dac_r <= writedata[7:0] & MASK_DAC;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cm_r <= RST_CM;
        end else if (wrEn && idx == IDX_CM) begin
            cm_r <= writedata[7:0] & MASK_CM;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dcpk_r <= RST_DCPK;
        end else if (wrEn && idx == IDX_DCPK) begin
            dcpk_r <= writedata[7:0] & MASK_DCPK;
        end
    end

    // variant decides which enhancement bits exist
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enh_r <= RST_ENH;
        end else if (wrEn && idx == IDX_ENH) begin
            enh_r <= writedata[7:0] & MASK_ENH;
        end
    end

    // ==========================================================
    // current limit boost after ring burst
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            boostActive_r <= 1'b0;
            boostCnt_r <= '0;
        end else if (!enh_r[BIT_BOOST]) begin
            boostActive_r <= 1'b0;
            boostCnt_r <= '0;
        end else if (ringBurstEnd) begin
            boostActive_r <= 1'b1;
            boostCnt_r <= CNT_W'(BOOST_CYCLES - 1);
        end else if (boostActive_r) begin
            if (boostCnt_r == '0) begin
                boostActive_r <= 1'b0;
            end else begin
                boostCnt_r <= boostCnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            loopLimitMa_r <= 6'h00;
        end else begin
            loopLimitMa_r <= boostActive_r ? LIMIT_BOOST_MA
                : programmedCurrentLimit;
        end
    end

    // ==========================================================
    // fsk enhancement and tone generator 1 clock
    // one mode flag steers the tone generator 1 clock rate
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fskMode_r <= 1'b0;
        end else begin
            fskMode_r <= enh_r[BIT_FSK] && relaySelectBit;
        end
    end

    // 24 kHz divide rounds down, so fast rate runs slightly high
    assign toneDiv = fskMode_r ? TONE_W'(TONE_FAST_DIV - 1)
        : TONE_W'(TONE_SLOW_DIV - 1);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            toneCnt_r <= '0;
            toneTick_r <= 1'b0;
        end else if (toneCnt_r >= toneDiv) begin
            toneCnt_r <= '0;
            toneTick_r <= 1'b1;
        end else begin
            toneCnt_r <= toneCnt_r + 1'b1;
            toneTick_r <= 1'b0;
        end
    end

    // ==========================================================
    // battery switch debounce, only high to low
    assign dbActive = !HAS_CONVERTER && enh_r[BIT_DEBOUNCE]
        && externalBatterySelect;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            batteryLowSel_r <= 1'b0;
            dbCnt_r <= '0;
        end else if (lowBatteryReq == batteryLowSel_r) begin
            dbCnt_r <= '0;
        end else if (!lowBatteryReq || !dbActive) begin
            batteryLowSel_r <= lowBatteryReq;
            dbCnt_r <= '0;
        end else if (dbCnt_r == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
            batteryLowSel_r <= 1'b1;
            dbCnt_r <= '0;
        end else begin
            dbCnt_r <= dbCnt_r + 1'b1;
        end
    end

    // ==========================================================
    // loop closure decision
    assign measure = enh_r[BIT_VLOOP] ? tipRingVoltage
        : loopCurrent;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            loopClosed_r <= 1'b0;
        end else if (!enh_r[BIT_HYST]) begin
            loopClosed_r <= measure > closeThreshUpper;
        end else if (loopClosed_r) begin
            loopClosed_r <= !(measure < closeThreshLower);
        end else begin
            loopClosed_r <= measure > closeThreshUpper;
        end
    end

    // ==========================================================
    // outputs
    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign monitorOffsetResultA = mon_r[7:4];
    assign monitorOffsetResultB = mon_r[3:0];
    assign dacPlusTrim = trim_r[3];
    assign dacMinusTrim = trim_r[2];
    assign adcPlusTrim = trim_r[1];
    assign adcMinusTrim = trim_r[0];
    assign audioDacOffsetResult = dac_r;
    assign commonModeBalanceResult = cm_r[5:0];
    assign dcPeakMonitorResult = dcpk_r[3:0];
    assign loopLimitMa = loopLimitMa_r;
    assign boostActive = boostActive_r;
    assign fskMode = fskMode_r;
    assign toneTick = toneTick_r;
    assign converterSpeedup = enh_r[BIT_SPEEDUP];
    assign externalImpedanceRef = enh_r[BIT_EXTREF];
    assign batteryLowSel = batteryLowSel_r;
    assign voltageLoopClosure = enh_r[BIT_VLOOP];
    assign converterSquelch = enh_r[BIT_SQUELCH];
    assign loopClosed = loopClosed_r;

    // ==========================================================
    // assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    mon_write_a:
    assert property (wrEn && idx == IDX_MON |=>
        mon_r == $past(writedata[7:0]))
        else $error("monitor offset write lost");
    trim_top_a:
    assert property (trim_r[7:4] == 4'h0)
        else $error("trim upper bits set");
    dac_write_a:
    assert property (wrEn && idx == IDX_DAC |=>
        dac_r == $past(writedata[7:0]))
        else $error("dac offset write lost");
    cm_top_a:
    assert property (cm_r[7:6] == 2'b00)
        else $error("common mode upper bits set");
    dcpk_top_a:
    assert property (dcpk_r[7:4] == 4'h0)
        else $error("dc peak upper bits set");
    boost_limit_a:
    assert property (enh_r[BIT_BOOST] && ringBurstEnd |=>
        ##1 loopLimitMa_r == LIMIT_BOOST_MA)
        else $error("boost limit not applied");
    fast_tone_a:
    assert property (fskMode_r && $rose(toneTick_r) |=>
        !toneTick_r [*8])
        else $error("tone tick too frequent");
    db_hold_a:
    assert property (dbActive && lowBatteryReq && !batteryLowSel_r
        && dbCnt_r < CNT_W'(DEBOUNCE_CYCLES - 1) |=> !batteryLowSel_r)
        else $error("battery switched before debounce");
    loop_plain_a:
    assert property (!enh_r[BIT_HYST] && measure > closeThreshUpper
        |=> loopClosed_r)
        else $error("loop closure missed");
    hyst_hold_a:
    assert property (enh_r[BIT_HYST] && loopClosed_r
        && measure >= closeThreshLower |=> loopClosed_r)
        else $error("hysteresis not held");
    enh_rsvd_a:
    assert property ((enh_r & ~MASK_ENH) == 8'h00)
        else $error("reserved enhancement bit set");
    bus_ack_a:
    assert property ((read || write) && waitrequest_r |=>
        !waitrequest_r ##1 waitrequest_r)
        else $error("bus answer late");
    trim_write_a:
    assert property (wrEn && idx == IDX_TRIM |=>
        trim_r == ($past(writedata[7:0]) & MASK_TRIM))
        else $error("trim write lost");
    cm_write_a:
    assert property (wrEn && idx == IDX_CM |=>
        cm_r == ($past(writedata[7:0]) & MASK_CM))
        else $error("common mode write lost");
    dcpk_write_a:
    assert property (wrEn && idx == IDX_DCPK |=>
        dcpk_r == ($past(writedata[7:0]) & MASK_DCPK))
        else $error("dc peak write lost");
    enh_write_a:
    assert property (wrEn && idx == IDX_ENH |=>
        enh_r == ($past(writedata[7:0]) & MASK_ENH))
        else $error("enhancement write lost");
    boost_off_a:
    assert property (!enh_r[BIT_BOOST] |=> !boostActive_r)
        else $error("boost left on");
    limit_plain_a:
    assert property (rst_n && !boostActive_r |=>
        loopLimitMa_r == $past(programmedCurrentLimit))
        else $error("programmed limit not used");
    fsk_mode_a:
    assert property (rst_n |=>
        fskMode_r == $past(enh_r[BIT_FSK] && relaySelectBit))
        else $error("fsk mode wrong");
    batt_follow_a:
    assert property (rst_n && !dbActive
        && lowBatteryReq != batteryLowSel_r |=>
        batteryLowSel_r == $past(lowBatteryReq))
        else $error("battery select did not follow");

    enh_write_c: cover property (wrEn && idx == IDX_ENH);
    boost_c: cover property ($fell(boostActive_r));
    fsk_tick_c: cover property (fskMode_r && toneTick_r);
    hyst_c: cover property (enh_r[BIT_HYST] && $fell(loopClosed_r));
endmodule : calib_enh_regs

/* File: logic/calib_enh_pkg.sv */
// constants for the calibration result and enhancement register bank
// Overview of operation
// - monitor offset register holds two 4-bit results, each reset 1000
// - analog trim register has four 1-bit trims in bits 3..0, top reads zero
// - audio DAC offset result is a full 8-bit field, reset zero
// - common-mode result is 6 bits, reset 0x20, bits 7:6 read zero
// - DC peak monitor result is 4 bits, reset 0x08, top nibble zero
// - boost bit raises loop limit to 41 mA after each ring burst
// - FSK bit with relay bit clocks tone generator 1 at 24 kHz
// - speedup bit picks multi-threshold converter control, converter only
// - impedance reference bit disconnects the internal reference resistor
// - no-converter variant debounces high-to-low battery switch by 60 ms
// - loop closure source bit picks loop current or tip-ring voltage
// - converter variant squelch bit suppresses converter noise in voice band
// - hysteresis bit applies upper and lower loop closure thresholds
package calib_enh_pkg;
    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_MON = 8'h67;
    localparam logic [7:0] IDX_TRIM = 8'h68;
    localparam logic [7:0] IDX_DAC = 8'h69;
    localparam logic [7:0] IDX_CM = 8'h6a;
    localparam logic [7:0] IDX_DCPK = 8'h6b;
    localparam logic [7:0] IDX_ENH = 8'h6c;
    // ==========================================================
    // reset values and writable masks
    localparam logic [7:0] RST_MON = 8'h88;
    localparam logic [7:0] RST_TRIM = 8'h00;
    localparam logic [7:0] RST_DAC = 8'h00;
    localparam logic [7:0] RST_CM = 8'h20;
    localparam logic [7:0] RST_DCPK = 8'h08;
    localparam logic [7:0] RST_ENH = 8'h00;
    localparam logic [7:0] MASK_MON = 8'hff;
    localparam logic [7:0] MASK_TRIM = 8'h0f;
    localparam logic [7:0] MASK_DAC = 8'hff;
    localparam logic [7:0] MASK_CM = 8'h3f;
    localparam logic [7:0] MASK_DCPK = 8'h0f;
    localparam logic [7:0] MASK_ENH_CONV = 8'hf7;
    localparam logic [7:0] MASK_ENH_NOCONV = 8'hdd;
    // ==========================================================
    // enhancement bit positions
    localparam int BIT_BOOST = 7;
    localparam int BIT_FSK = 6;
    localparam int BIT_SPEEDUP = 5;
    localparam int BIT_EXTREF = 4;
    localparam int BIT_DEBOUNCE = 3;
    localparam int BIT_VLOOP = 2;
    localparam int BIT_SQUELCH = 1;
    localparam int BIT_HYST = 0;
    // ==========================================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int TONE_FAST_HZ = 24_000;
    localparam int TONE_SLOW_HZ = 8_000;
    localparam int TONE_FAST_DIV = CLK_HZ / TONE_FAST_HZ;
    localparam int TONE_SLOW_DIV = CLK_HZ / TONE_SLOW_HZ;
    localparam int DEBOUNCE_MS = 60;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int BOOST_MS = 50;
    localparam int BOOST_CYC = BOOST_MS * (CLK_HZ / 1000);
    localparam logic [5:0] LIMIT_BOOST_MA = 6'd41;
    localparam int CNT_W = 20;
    localparam int TONE_W = 11;
endpackage : calib_enh_pkg

/* File: tb/tb.sv */
// self-checking bench for the calibration and enhancement register bank
`timescale 1ns/1ps
module tb;
    import calib_enh_pkg::*;
    localparam int DEB = 20;
    localparam int BST = 10;
    logic mclk, rst_n, read, write, ringBurstEnd, relaySelectBit;
    logic externalBatterySelect, lowBatteryReq, waitrequest, dacPlusTrim;
    logic dacMinusTrim, adcPlusTrim, adcMinusTrim, boostActive, fskMode;
    logic toneTick, converterSpeedup, externalImpedanceRef, batteryLowSel;
    logic voltageLoopClosure, converterSquelch, loopClosed;
    logic [9:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable, monitorOffsetResultA, monitorOffsetResultB;
    logic [3:0] dcPeakMonitorResult;
    logic [5:0] programmedCurrentLimit, commonModeBalanceResult, loopLimitMa;
    logic [7:0] audioDacOffsetResult;
    logic [15:0] loopCurrent, tipRingVoltage, closeThreshUpper;
    logic [15:0] closeThreshLower;
    int num_errors = 0;
    int checks_done = 0;
    // ==========================================================
    // device under test, variant without converter to reach debounce
    calib_enh_regs #(.HAS_CONVERTER(1'b0), .DEBOUNCE_CYCLES(DEB),
        .BOOST_CYCLES(BST)) i_calib_enh_regs (.mclk(mclk), .rst_n(rst_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .ringBurstEnd(ringBurstEnd),
        .programmedCurrentLimit(programmedCurrentLimit),
        .relaySelectBit(relaySelectBit),
        .externalBatterySelect(externalBatterySelect),
        .lowBatteryReq(lowBatteryReq), .loopCurrent(loopCurrent),
        .tipRingVoltage(tipRingVoltage),
        .closeThreshUpper(closeThreshUpper),
        .closeThreshLower(closeThreshLower),
        .monitorOffsetResultA(monitorOffsetResultA),
        .monitorOffsetResultB(monitorOffsetResultB),
        .dacPlusTrim(dacPlusTrim), .dacMinusTrim(dacMinusTrim),
        .adcPlusTrim(adcPlusTrim), .adcMinusTrim(adcMinusTrim),
        .audioDacOffsetResult(audioDacOffsetResult),
        .commonModeBalanceResult(commonModeBalanceResult),
        .dcPeakMonitorResult(dcPeakMonitorResult),
        .loopLimitMa(loopLimitMa), .boostActive(boostActive),
        .fskMode(fskMode), .toneTick(toneTick),
        .converterSpeedup(converterSpeedup),
        .externalImpedanceRef(externalImpedanceRef),
        .batteryLowSel(batteryLowSel),
        .voltageLoopClosure(voltageLoopClosure),
        .converterSquelch(converterSquelch), .loopClosed(loopClosed));
    // ==========================================================
    // clock and shared tasks
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // request held until waitrequest is sampled low at an edge
    task automatic bus(input bit wr, input logic [7:0] idx,
        input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge mclk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        read <= !wr;
        write <= wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check("bus answer", 16'h0, 16'h1);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h0, q);
        check("readback", {8'h0, q}, {8'h0, exp});
    endtask : rd
    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] ix[6] = '{IDX_MON, IDX_TRIM, IDX_DAC, IDX_CM, IDX_DCPK,
            IDX_ENH};
        logic [7:0] rv[6] = '{8'h88, 8'h00, 8'h00, 8'h20, 8'h08, 8'h00};
        logic [7:0] mk[6] = '{8'hff, 8'h0f, 8'hff, 8'h3f, 8'h0f, 8'hdd};
        for (int i = 0; i < 6; i++) begin
            rd(ix[i], rv[i]);
            wr(ix[i], 8'ha5);
            rd(ix[i], 8'ha5 & mk[i]);
            wr(ix[i], 8'hff);
            rd(ix[i], mk[i]);
        end
        for (int i = 0; i < 5; i++) wr(ix[i], 8'ha5);
        repeat (2) @(posedge mclk);
        check("mon", {monitorOffsetResultA,
            monitorOffsetResultB}, 16'ha5);
        check("trim", {dacPlusTrim, dacMinusTrim, adcPlusTrim,
            adcMinusTrim}, 16'h5);
        check("audio offset", audioDacOffsetResult, 16'ha5);
        check("cm", commonModeBalanceResult, 16'h25);
        check("dcpk", dcPeakMonitorResult, 16'h5);
        wr(8'h70, 8'h33);
        rd(8'h70, 8'h00);
        rd(IDX_MON, 8'ha5);
    endtask : t_regs
    task automatic t_enh_bits();
        wr(IDX_ENH, 8'hff);
        repeat (2) @(posedge mclk);
        check("extref", externalImpedanceRef, 16'h1);
        check("vloop", voltageLoopClosure, 16'h1);
        check("speedup", converterSpeedup, 16'h0);
        check("squelch", converterSquelch, 16'h0);
        wr(IDX_ENH, 8'h00);
        repeat (2) @(posedge mclk);
        check("extref off", externalImpedanceRef, 16'h0);
    endtask : t_enh_bits
    // second gap is measured, first may straddle the mode change
    task automatic tone_gap(input logic [15:0] exp);
        int g;
        for (int k = 0; k < 2; k++) begin
            g = 0;
            do begin
                @(posedge mclk);
                g++;
            end while (toneTick !== 1'b1 && g < 3000);
        end
        check("tone gap", g[15:0], exp);
    endtask : tone_gap
    task automatic t_fsk();
        wr(IDX_ENH, 8'h40);
        repeat (2) @(posedge mclk);
        check("fsk no relay", fskMode, 16'h0);
        tone_gap(16'd1250);
        relaySelectBit <= 1'b1;
        repeat (3) @(posedge mclk);
        check("fsk relay", fskMode, 16'h1);
        tone_gap(16'd416);
        wr(IDX_ENH, 8'h00);
        repeat (2) @(posedge mclk);
        check("fsk off", fskMode, 16'h0);
    endtask : t_fsk
    task automatic ring_pulse();
        @(posedge mclk);
        ringBurstEnd <= 1'b1;
        @(posedge mclk);
        ringBurstEnd <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : ring_pulse
    task automatic t_boost();
        ring_pulse();
        check("no boost", loopLimitMa, 16'd20);
        wr(IDX_ENH, 8'h80);
        ring_pulse();
        check("boost on", boostActive, 16'h1);
        check("boost lim", loopLimitMa, 16'd41);
        repeat (BST + 5) @(posedge mclk);
        check("boost end", loopLimitMa, 16'd20);
        wr(IDX_ENH, 8'h00);
    endtask : t_boost
    task automatic t_debounce();
        wr(IDX_ENH, 8'h08);
        externalBatterySelect <= 1'b1;
        lowBatteryReq <= 1'b1;
        repeat (DEB / 2) @(posedge mclk);
        check("deb wait", batteryLowSel, 16'h0);
        repeat (DEB) @(posedge mclk);
        check("deb done", batteryLowSel, 16'h1);
        lowBatteryReq <= 1'b0;
        repeat (3) @(posedge mclk);
        check("to high", batteryLowSel, 16'h0);
        externalBatterySelect <= 1'b0;
        lowBatteryReq <= 1'b1;
        repeat (3) @(posedge mclk);
        check("no deb", batteryLowSel, 16'h1);
        lowBatteryReq <= 1'b0;
        wr(IDX_ENH, 8'h00);
    endtask : t_debounce
    task automatic loop_at(input logic [15:0] cur, input logic exp);
        @(posedge mclk);
        loopCurrent <= cur;
        repeat (3) @(posedge mclk);
        check("loop", loopClosed, {15'h0, exp});
    endtask : loop_at
    task automatic t_loop();
        loop_at(16'd200, 1'b1);
        loop_at(16'd80, 1'b0);
        wr(IDX_ENH, 8'h01);
        loop_at(16'd200, 1'b1);
        loop_at(16'd80, 1'b1);
        loop_at(16'd40, 1'b0);
        loop_at(16'd80, 1'b0);
        wr(IDX_ENH, 8'h04);
        tipRingVoltage <= 16'd300;
        loop_at(16'd0, 1'b1);
        wr(IDX_ENH, 8'h00);
        loop_at(16'd0, 1'b0);
    endtask : t_loop
    // mid-run reset must bring written registers back
    task automatic t_reset();
        wr(IDX_MON, 8'h3c);
        wr(IDX_ENH, 8'h10);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        check("rst extref", externalImpedanceRef, 16'h0);
        check("rst mon", {monitorOffsetResultA,
            monitorOffsetResultB}, {8'h0, RST_MON});
        rst_n <= 1'b1;
        rd(IDX_MON, RST_MON);
        rd(IDX_CM, RST_CM);
        rd(IDX_DCPK, RST_DCPK);
    endtask : t_reset
    // ==========================================================
    // main sequence and watchdog
    initial begin
        rst_n = 1'b0;
        {read, write, ringBurstEnd, relaySelectBit} = 4'h0;
        {externalBatterySelect, lowBatteryReq} = 2'b00;
        address = 10'h0;
        writedata = 32'h0;
        byteenable = 4'hf;
        programmedCurrentLimit = 6'd20;
        {loopCurrent, tipRingVoltage} = 32'h0;
        closeThreshUpper = 16'd100;
        closeThreshLower = 16'd50;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_enh_bits();
        t_fsk();
        t_boost();
        t_debounce();
        t_loop();
        t_reset();
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        finish_test();
    end
endmodule : tb
